// *** hdl/dif_consts.vh ***
// Purpose: constants for the digital input function decoder
// Assumes: function codes 5 bits wide, clock 40 MHz
// Notes: second code column is folded onto the first in the decoder
`ifndef DIF_CONSTS_VH
`define DIF_CONSTS_VH

`define DIF_FN_W 5
`define DIF_FN_NONE 5'h00
`define DIF_FN_RESET 5'h01
`define DIF_FN_COAST_N 5'h02
`define DIF_FN_RST_COAST_N 5'h03
`define DIF_FN_DCBRAKE_N 5'h04
`define DIF_FN_INTERLOCK 5'h05
`define DIF_FN_START 5'h06
`define DIF_FN_REVERSE 5'h07
`define DIF_FN_REV_START 5'h08
`define DIF_FN_FRZ_REF 5'h09
`define DIF_FN_FRZ_OUT 5'h0A
`define DIF_FN_MANUAL 5'h0B
`define DIF_FN_AUTO 5'h0C
`define DIF_FN_FIRE 5'h0D
`define DIF_FN_FIRE_N 5'h0E
`define DIF_FN_SETUP_LSB 5'h0F
`define DIF_FN_SETUP_MSB 5'h10
`define DIF_FN_PRESET_ON 5'h11
`define DIF_FN_PRESET_LSB 5'h12
`define DIF_FN_PRESET_MSB 5'h13
`define DIF_FN_SPEED_UP 5'h14
`define DIF_FN_SPEED_DN 5'h15
`define DIF_FN_RUN_PERMIT 5'h16
`define DIF_FN_JOG 5'h17
`define DIF_FN_DATA_LOCK 5'h18
`define DIF_FN_CLK_EN 5'h19
`define DIF_FN_PULSE_REF 5'h1A

// second column: codes from here up sit one higher, clock enable excepted
`define DIF_COLB_SHIFT_LO 5'h0C
`define DIF_COLB_SHIFT_HI 5'h1B

`define DIF_MULTI_SETUP 3'h5
`define DIF_REF_REMOTE_PRESET 2'h2

`define DIF_CLK_KHZ 40000
`define DIF_MIN_PULSE_MS 3

`endif

// *** hdl/dif_decoder.v ***
// Purpose: decode programmable digital inputs into drive commands
// Assumes: inputs are asynchronous pins; config ports are on core_clk_i
// Notes: every output is registered; pin to output is three edges
//
// Functional notes
// - inputs set to no function are ignored entirely
// - reset input clears a non-locking alarm on rising edge only
// - coast input low turns output stage off at once
// - reset-and-coast coasts while low, resets alarm on falling edge
// - dc brake input low brakes only if current and time nonzero
// - interlock low coasts and raises external fault until reset or off
// - start input high requests run, low requests stop
// - stop from start input is ignored while in current limit
// - reversing high reverses, never starts, disabled in closed loop
// - reverse-and-start runs and reverses; far side never drives start too
// - freeze reference holds reference, changed only by speed up/down
// - freeze output holds frequency; only dc brake or a coast input stops the motor
// - setup select bits pick set one to four in multi-setup mode
// - preset-on picks preset reference high, remote low, if remote/preset
// - preset select bits pick preset one to four
// - speed up/down ignored unless a freeze function is active
// - held speed up/down ramps at configured up or down rate
// - each pulse steps 0.1 percent or 0.1 Hz; pulses 3 ms high and low
// - run needs start AND run permissive; any permissive input suffices
// - jog forces jog frequency and start, ignored while coasting
// - data lock blocks panel writes, bus writes still pass
// - code 25 is clock enable in both columns, fire inverse 14/15
// - manual start runs high, stops low; off/stop without automatic mode
// - automatic mode wins when manual and automatic are both high
// - fire mode runs with auto reset until fire input or coast drops
`timescale 1ns/10ps
`include "dif_consts.vh"

module dif_decoder #(
  parameter NUM_IN = 8,
  parameter [NUM_IN-1:0] COLB_MASK = 8'hF0,
  parameter MIN_PULSE_CYC = `DIF_MIN_PULSE_MS * `DIF_CLK_KHZ
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [NUM_IN-1:0] din_i,
  input wire [NUM_IN*`DIF_FN_W-1:0] func_sel_i,
  input wire closed_loop_i,
  input wire current_limit_i,
  input wire [7:0] dc_brake_current_i,
  input wire [7:0] dc_brake_time_i,
  input wire [2:0] active_setup_i,
  input wire [1:0] ref_type_i,
  input wire fire_enable_i,
  input wire alarm_pending_i,
  input wire alarm_locked_i,
  input wire off_key_i,
  input wire panel_write_req_i,
  input wire bus_write_req_i,
  output reg coast_o,
  output reg dc_brake_o,
  output reg run_o,
  output reg reverse_o,
  output reg jog_o,
  output reg alarm_reset_o,
  output reg ext_fault_o,
  output reg freeze_ref_o,
  output reg freeze_out_o,
  output reg ramp_up_o,
  output reg ramp_down_o,
  output reg step_up_o,
  output reg step_down_o,
  output reg multi_setup_o,
  output reg [1:0] setup_sel_o,
  output reg preset_active_o,
  output reg [1:0] preset_sel_o,
  output reg manual_mode_o,
  output reg automatic_run_select_o,
  output reg off_stop_o,
  output reg fire_mode_o,
  output reg clk_enable_o,
  output reg pulse_ref_o,
  output reg panel_write_ok_o,
  output reg bus_write_ok_o
);

  // 17 bits hold the full 3 ms count at 40 MHz
  localparam CW = 17;
  localparam [31:0] PULSE_FULL = MIN_PULSE_CYC;
  localparam [CW-1:0] PULSE_CNT = PULSE_FULL[CW-1:0];

  // fold a second-column code onto the first column
  function [`DIF_FN_W-1:0] norm_code;
    input [`DIF_FN_W-1:0] code;
    input colb;
    begin
      norm_code = code;
      if (colb && code != `DIF_FN_CLK_EN &&
          code >= `DIF_COLB_SHIFT_LO + 5'h01 &&
          code <= `DIF_COLB_SHIFT_HI)
        norm_code = code - 5'h01;
    end
  endfunction

  reg [NUM_IN-1:0] s1_ff;
  reg [NUM_IN-1:0] s2_ff;
  reg [NUM_IN-1:0] prev_ff;
  reg [CW-1:0] up_cnt_ff;
  reg [CW-1:0] dn_cnt_ff;

  // per-function summaries indexed by function code
  reg [31:0] asg;
  reg [31:0] hi;
  reg [31:0] lo;
  reg [31:0] rise;
  reg [31:0] fall;
  reg [`DIF_FN_W-1:0] code;
  integer i;

  always @* begin
    asg = 32'h0000_0000;
    hi = 32'h0000_0000;
    lo = 32'h0000_0000;
    rise = 32'h0000_0000;
    fall = 32'h0000_0000;
    code = `DIF_FN_NONE;
    for (i = 0; i < NUM_IN; i = i + 1) begin
      code = norm_code(func_sel_i[i*`DIF_FN_W +: `DIF_FN_W], COLB_MASK[i]);
      if (code != `DIF_FN_NONE) begin
        asg[code] = 1'b1;
        if (s2_ff[i])
          hi[code] = 1'b1;
        else
          lo[code] = 1'b1;
        if (s2_ff[i] && !prev_ff[i])
          rise[code] = 1'b1;
        if (!s2_ff[i] && prev_ff[i])
          fall[code] = 1'b1;
      end
    end
  end

  wire coast_now = lo[`DIF_FN_COAST_N] | lo[`DIF_FN_RST_COAST_N] |
                   lo[`DIF_FN_INTERLOCK];
  wire brake_cfg_ok = (dc_brake_current_i != 8'h00) &&
                      (dc_brake_time_i != 8'h00);
  wire brake_now = lo[`DIF_FN_DCBRAKE_N] & brake_cfg_ok;

  // reversing functions drop out entirely in closed loop
  wire rev_start = hi[`DIF_FN_REV_START] & ~closed_loop_i;
  wire rev_now = (hi[`DIF_FN_REVERSE] & ~closed_loop_i) |
                 rev_start;
  wire start_now = hi[`DIF_FN_START] | rev_start;
  wire permit_ok = asg[`DIF_FN_RUN_PERMIT] ?
                   hi[`DIF_FN_RUN_PERMIT] : 1'b1;
  wire auto_now = hi[`DIF_FN_AUTO];
  wire manual_now = hi[`DIF_FN_MANUAL] & ~auto_now;
  wire off_now = (asg[`DIF_FN_MANUAL] | asg[`DIF_FN_AUTO]) &
                 ~hi[`DIF_FN_MANUAL] & ~auto_now;

  wire fire_now = fire_enable_i & ~coast_now &
                  (hi[`DIF_FN_FIRE] | lo[`DIF_FN_FIRE_N]);
  wire jog_now = hi[`DIF_FN_JOG] & ~coast_now;

  wire frz_ref = hi[`DIF_FN_FRZ_REF];
  wire frz_out = hi[`DIF_FN_FRZ_OUT];
  wire frz_any = frz_ref | frz_out;
  // both inputs high counts as speed down
  wire up_hold = frz_any & hi[`DIF_FN_SPEED_UP] & ~hi[`DIF_FN_SPEED_DN];
  wire dn_hold = frz_any & hi[`DIF_FN_SPEED_DN];

  wire run_req = (start_now & permit_ok) | manual_now |
                 jog_now | fire_now;
  // a dropped start is not honoured in current limit or frozen output;
  // with frozen output only the brake or a coast input can stop the motor
  wire hold_run = run_o & ~brake_now &
                  (current_limit_i | frz_out);
  wire nxt_run = ~coast_now & (run_req | hold_run);

  wire reset_evt = rise[`DIF_FN_RESET] |
                   fall[`DIF_FN_RST_COAST_N];
  wire nxt_alarm_reset = alarm_pending_i & ~alarm_locked_i &
                         (reset_evt | fire_now);
  // a new interlock low wins over a clear in the same cycle
  wire nxt_ext_fault = lo[`DIF_FN_INTERLOCK] |
                       (ext_fault_o & ~reset_evt & ~off_key_i);

  wire [1:0] setup_bits = {hi[`DIF_FN_SETUP_MSB], hi[`DIF_FN_SETUP_LSB]};
  wire [1:0] preset_bits = {hi[`DIF_FN_PRESET_MSB],
                            hi[`DIF_FN_PRESET_LSB]};
  wire multi_now = (active_setup_i == `DIF_MULTI_SETUP);

  // two stages before any decode; prev_ff only feeds edge detection
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_ff <= {NUM_IN{1'b0}};
      s2_ff <= {NUM_IN{1'b0}};
      prev_ff <= {NUM_IN{1'b0}};
    end else begin
      s1_ff <= din_i;
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  // ramping starts only after a hold longer than a legal step pulse,
  // so a short pulse gives one step and never a ramp
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      up_cnt_ff <= {CW{1'b0}};
      dn_cnt_ff <= {CW{1'b0}};
    end else begin
      if (!up_hold)
        up_cnt_ff <= {CW{1'b0}};
      else if (up_cnt_ff != PULSE_CNT)
        up_cnt_ff <= up_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      if (!dn_hold)
        dn_cnt_ff <= {CW{1'b0}};
      else if (dn_cnt_ff != PULSE_CNT)
        dn_cnt_ff <= dn_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // stop commands: coast has priority over the brake
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      coast_o <= 1'b0;
      dc_brake_o <= 1'b0;
    end else begin
      coast_o <= coast_now;
      dc_brake_o <= brake_now & ~coast_now;
    end
  end

  // motion commands
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      run_o <= 1'b0;
      reverse_o <= 1'b0;
      jog_o <= 1'b0;
    end else begin
      run_o <= nxt_run;
      reverse_o <= rev_now;
      jog_o <= jog_now;
    end
  end

  // alarm handling: reset pulses on a reset edge and is held in fire mode, external fault is sticky
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm_reset_o <= 1'b0;
      ext_fault_o <= 1'b0;
    end else begin
      alarm_reset_o <= nxt_alarm_reset;
      ext_fault_o <= nxt_ext_fault;
    end
  end

  // the core keeps the held value itself, across stop and power loss
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      freeze_ref_o <= 1'b0;
      freeze_out_o <= 1'b0;
    end else begin
      freeze_ref_o <= frz_ref;
      freeze_out_o <= frz_out;
    end
  end

  // speed up/down: one step per rising edge, ramp after a long hold
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ramp_up_o <= 1'b0;
      ramp_down_o <= 1'b0;
      step_up_o <= 1'b0;
      step_down_o <= 1'b0;
    end else begin
      ramp_up_o <= up_hold && (up_cnt_ff == PULSE_CNT);
      ramp_down_o <= dn_hold && (dn_cnt_ff == PULSE_CNT);
      step_up_o <= frz_any & rise[`DIF_FN_SPEED_UP] &
                   ~hi[`DIF_FN_SPEED_DN];
      step_down_o <= frz_any & rise[`DIF_FN_SPEED_DN];
    end
  end

  // setup and preset selection
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      multi_setup_o <= 1'b0;
      setup_sel_o <= 2'h0;
      preset_active_o <= 1'b0;
      preset_sel_o <= 2'h0;
    end else begin
      multi_setup_o <= multi_now;
      setup_sel_o <= multi_now ? setup_bits : 2'h0;
      preset_active_o <= (ref_type_i == `DIF_REF_REMOTE_PRESET) &
                         hi[`DIF_FN_PRESET_ON];
      preset_sel_o <= preset_bits;
    end
  end

  // hand/auto/off switch modes
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      manual_mode_o <= 1'b0;
      automatic_run_select_o <= 1'b0;
      off_stop_o <= 1'b0;
    end else begin
      manual_mode_o <= manual_now;
      automatic_run_select_o <= auto_now;
      off_stop_o <= off_now;
    end
  end

  // fire mode drops with the fire input or an open coast input
  always @(posedge core_clk_i) begin
    if (rst_i)
      fire_mode_o <= 1'b0;
    else
      fire_mode_o <= fire_now;
  end

  // plain level functions passed to the core
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      clk_enable_o <= 1'b0;
      pulse_ref_o <= 1'b0;
    end else begin
      clk_enable_o <= hi[`DIF_FN_CLK_EN];
      pulse_ref_o <= hi[`DIF_FN_PULSE_REF];
    end
  end

  // data lock only gates the local panel; the bus always passes
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      panel_write_ok_o <= 1'b0;
      bus_write_ok_o <= 1'b0;
    end else begin
      panel_write_ok_o <= panel_write_req_i &
                          ~hi[`DIF_FN_DATA_LOCK];
      bus_write_ok_o <= bus_write_req_i;
    end
  end

endmodule

// *** verification/dif_switch_model.sv ***
// Purpose: bank of external switches on the decoder pins
// Assumes: bench sets the wanted level of each switch
// Notes: levels move on the rising edge after the bench sets them
`timescale 1ns/10ps
module dif_switch_model #(parameter N = 8) (
  input wire clk_i,
  input wire [N-1:0] want_i,
  output reg [N-1:0] pin_o
);
  initial pin_o = {N{1'b0}};
  // bench writes want_i on the falling edge; taking it on the rising
  // edge avoids a race with that write
  // one start source, pulses held long enough
  always @(posedge clk_i) pin_o <= want_i;
endmodule

// *** verification/dif_decoder_props.sv ***
// Purpose: timing checks on the decoder outputs
// Assumes: config ports reach outputs in one edge
// Notes: bound onto every decoder instance
`timescale 1ns/10ps
module dif_decoder_props (
  input wire core_clk_i,
  input wire rst_i,
  input wire closed_loop_i,
  input wire alarm_pending_i,
  input wire panel_write_req_i,
  input wire bus_write_req_i,
  input wire [7:0] dc_brake_current_i,
  input wire [7:0] dc_brake_time_i,
  input wire [2:0] active_setup_i,
  input wire coast_o,
  input wire dc_brake_o,
  input wire run_o,
  input wire reverse_o,
  input wire jog_o,
  input wire alarm_reset_o,
  input wire freeze_ref_o,
  input wire freeze_out_o,
  input wire step_up_o,
  input wire multi_setup_o,
  input wire panel_write_ok_o,
  input wire bus_write_ok_o,
  input wire [1:0] setup_sel_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_bus_write_pass: assert property
    (bus_write_req_i |=> bus_write_ok_o) else $error("bus write not passed");
  a_panel_needs_req: assert property
    (panel_write_ok_o |-> $past(panel_write_req_i)) else $error("panel ok");
  a_step_needs_freeze: assert property
    (step_up_o |-> freeze_ref_o || freeze_out_o) else $error("step unfrozen");
  a_step_single_cycle: assert property
    (step_up_o |=> !step_up_o) else $error("step too long");
  a_jog_not_coast: assert property
    (jog_o |-> !coast_o) else $error("jog while coast");
  a_run_not_coast: assert property
    (run_o |-> !coast_o) else $error("run while coast");
  a_reverse_closed_loop: assert property
    (closed_loop_i |=> !reverse_o) else $error("reverse in closed loop");
  a_brake_needs_config: assert property
    (dc_brake_o |->
    $past(dc_brake_current_i) != 0 && $past(dc_brake_time_i) != 0)
    else $error("brake without config");
  a_reset_needs_alarm: assert property
    (alarm_reset_o |-> $past(alarm_pending_i)) else $error("reset no alarm");
  a_setup_single_set: assert property
    (!multi_setup_o |-> setup_sel_o == 2'h0) else $error("setup sel");
  c_step: cover property (step_up_o);
  c_alarm_reset: cover property (alarm_reset_o);
  c_brake: cover property (dc_brake_o);
endmodule
bind dif_decoder dif_decoder_props u_props (.core_clk_i, .rst_i,
  .closed_loop_i, .alarm_pending_i, .panel_write_req_i, .bus_write_req_i,
  .dc_brake_current_i, .dc_brake_time_i, .active_setup_i, .coast_o,
  .dc_brake_o, .run_o, .reverse_o, .jog_o, .alarm_reset_o, .freeze_ref_o,
  .freeze_out_o, .step_up_o, .multi_setup_o, .panel_write_ok_o,
  .bus_write_ok_o, .setup_sel_o);

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the input function decoder
// Assumes: 40 MHz clock, pulse hold shortened to 8 cycles
// Notes: pins reach outputs a few edges after the switches move
`timescale 1ns/10ps
module tb_top;
  reg core_clk_i = 0, rst_i = 1, closed_loop_i = 0, current_limit_i = 0;
  reg fire_enable_i = 0, alarm_pending_i = 0, alarm_locked_i = 0;
  reg off_key_i = 0, panel_write_req_i = 0, bus_write_req_i = 0;
  reg [7:0] dc_brake_current_i = 8'h00, dc_brake_time_i = 8'h05;
  reg [2:0] active_setup_i = 3'h5;
  reg [1:0] ref_type_i = 2'h2;
  reg [39:0] func_sel_i = 40'h0;
  reg [7:0] want = 8'h00;
  wire [7:0] pins;
  wire coast_o, dc_brake_o, run_o, reverse_o, jog_o, alarm_reset_o;
  wire ext_fault_o, freeze_ref_o, freeze_out_o, ramp_up_o, ramp_down_o;
  wire step_up_o, step_down_o, multi_setup_o, preset_active_o;
  wire manual_mode_o, automatic_run_select_o, off_stop_o, fire_mode_o;
  wire clk_enable_o, pulse_ref_o, panel_write_ok_o, bus_write_ok_o;
  wire [1:0] setup_sel_o, preset_sel_o;
  integer mismatches = 0, checks_done = 0, na = 0, ns = 0, nd = 0, m, v;
  dif_decoder #(.MIN_PULSE_CYC(8)) DUT (.din_i(pins), .core_clk_i, .rst_i,
    .func_sel_i, .closed_loop_i, .current_limit_i, .dc_brake_current_i,
    .dc_brake_time_i, .active_setup_i, .ref_type_i, .fire_enable_i,
    .alarm_pending_i, .alarm_locked_i, .off_key_i, .panel_write_req_i,
    .bus_write_req_i, .coast_o, .dc_brake_o, .run_o, .reverse_o, .jog_o,
    .alarm_reset_o, .ext_fault_o, .freeze_ref_o, .freeze_out_o, .ramp_up_o,
    .ramp_down_o, .step_up_o, .step_down_o, .multi_setup_o, .setup_sel_o,
    .preset_active_o, .preset_sel_o, .manual_mode_o, .automatic_run_select_o,
    .off_stop_o, .fire_mode_o, .clk_enable_o, .pulse_ref_o,
    .panel_write_ok_o, .bus_write_ok_o);
  dif_switch_model #(.N(8)) SW (.clk_i(core_clk_i), .want_i(want),
    .pin_o(pins));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    na <= na + alarm_reset_o;
    ns <= ns + step_up_o;
    nd <= nd + step_down_o;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge core_clk_i);
  endtask
  // upper inputs use the second code column, shifted by one from code 12
  task fn(input integer k, input [4:0] c);
    begin
      func_sel_i[k*5 +: 5] = (k > 3 && c > 11 && c != 25) ? c + 1 : c;
      cyc(2);
    end
  endtask
  task pin(input integer k, input b);
    begin
      want[k] = b;
      cyc(6);
    end
  endtask
  task td(input integer t);
    $display("test %0d done", t);
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    cyc(20000);
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial begin
    cyc(5);
    rst_i = 0;
    cyc(1);
    fn(0, 5'h06); pin(0, 1); chk(run_o, 1);
    fn(1, 5'h00); pin(1, 1); chk(run_o, 1); chk(coast_o, 0);
    fn(2, 5'h16); cyc(4); chk(run_o, 0);
    fn(3, 5'h16); pin(3, 1); chk(run_o, 1);
    current_limit_i = 1; pin(0, 0); chk(run_o, 1);
    current_limit_i = 0; cyc(6); chk(run_o, 0);
    fn(4, 5'h02); cyc(4); chk(coast_o, 1);
    fn(5, 5'h17); pin(5, 1); chk(jog_o, 0);
    pin(4, 1); chk(jog_o, 1); chk(run_o, 1);
    pin(5, 0); td(1);
    alarm_pending_i = 1; fn(2, 5'h01); m = na;
    pin(2, 1); chk(na - m, 1); pin(2, 0); chk(na - m, 1);
    fn(2, 5'h03); chk(coast_o, 1); m = na;
    pin(2, 1); pin(2, 0); chk(na - m, 1); chk(coast_o, 1);
    pin(2, 1); alarm_pending_i = 0; td(2);
    pin(3, 0); fn(3, 5'h14); m = ns;
    pin(3, 1); pin(3, 0); chk(ns - m, 0);
    fn(1, 5'h09); cyc(4); chk(freeze_ref_o, 1);
    pin(3, 1); chk(ns - m, 1);
    cyc(8); chk(ramp_up_o, 1); pin(3, 0); td(3);
    fn(0, 5'h0F); fn(1, 5'h10); fn(2, 5'h12); fn(3, 5'h13);
    for (v = 0; v < 4; v = v + 1) begin
      want[3:0] = {v[1], v[0], v[1], v[0]};
      cyc(6);
      chk(setup_sel_o, v);
      chk(preset_sel_o, v);
    end
    chk(multi_setup_o, 1);
    active_setup_i = 3'h0; cyc(2); chk(setup_sel_o, 0);
    chk(multi_setup_o, 0); td(4);
    fn(5, 5'h07); pin(5, 1); chk(reverse_o, 1); chk(run_o, 0);
    closed_loop_i = 1; cyc(2); chk(reverse_o, 0); td(5);
    closed_loop_i = 0; fn(0, 5'h18); panel_write_req_i = 1;
    bus_write_req_i = 1; cyc(2); chk(panel_write_ok_o, 0);
    chk(bus_write_ok_o, 1); pin(0, 0); chk(panel_write_ok_o, 1);
    fn(7, 5'h04); cyc(4); chk(dc_brake_o, 0);
    dc_brake_current_i = 8'h10; cyc(2); chk(dc_brake_o, 1);
    pin(7, 1); fn(7, 5'h19); chk(clk_enable_o, 1);
    fire_enable_i = 1; fn(6, 5'h0E); cyc(4); chk(fire_mode_o, 1);
    td(6);
    chk(run_o, 1); alarm_pending_i = 1; cyc(2);
    chk(alarm_reset_o, 1); alarm_pending_i = 0;
    pin(4, 0); chk(fire_mode_o, 0); chk(coast_o, 1);
    pin(4, 1); chk(fire_mode_o, 1);
    pin(6, 1); chk(fire_mode_o, 0); chk(run_o, 0);
    fire_enable_i = 0; td(7);
    fn(4, 5'h05); pin(4, 0); chk(coast_o, 1); chk(ext_fault_o, 1);
    pin(4, 1); chk(ext_fault_o, 1); chk(coast_o, 0);
    off_key_i = 1; cyc(2); chk(ext_fault_o, 0); off_key_i = 0;
    pin(4, 0); pin(4, 1); chk(ext_fault_o, 1);
    fn(5, 5'h01); pin(5, 0); pin(5, 1); chk(ext_fault_o, 0); td(8);
    fn(4, 5'h0B); chk(manual_mode_o, 1); chk(run_o, 1);
    fn(5, 5'h0C); chk(automatic_run_select_o, 1);
    chk(manual_mode_o, 0); chk(run_o, 0);
    pin(5, 0); chk(manual_mode_o, 1); chk(run_o, 1);
    pin(4, 0); chk(off_stop_o, 1); chk(run_o, 0); td(9);
    fn(5, 5'h08); pin(5, 1); chk(run_o, 1); chk(reverse_o, 1);
    closed_loop_i = 1; cyc(2); chk(run_o, 0); chk(reverse_o, 0);
    closed_loop_i = 0; pin(5, 0); td(10);
    fn(0, 5'h0A); pin(0, 1); chk(freeze_out_o, 1);
    fn(1, 5'h06); chk(run_o, 1); pin(1, 0); chk(run_o, 1);
    fn(7, 5'h04); pin(7, 0); chk(dc_brake_o, 1); chk(run_o, 0);
    pin(7, 1); fn(3, 5'h15); pin(3, 0); m = nd;
    pin(3, 1); chk(nd - m, 1);
    cyc(8); chk(ramp_down_o, 1);
    pin(3, 0); chk(ramp_down_o, 0);
    fn(2, 5'h11); chk(preset_active_o, 1);
    ref_type_i = 2'h0; cyc(2); chk(preset_active_o, 0);
    ref_type_i = 2'h2; fn(6, 5'h1A); chk(pulse_ref_o, 1);
    td(11);
    end_of_test;
  end
endmodule
